// File: inc/tcp_pkg.sv
// Package of constants and types for the timer with capture, compare and PWM
//
// Overview of operation
// - Standard variant: 16-bit counter, four channels
// - Wide variant identical but 32-bit wide
// - Each channel: capture, compare or PWM
// - Capture copies counter on selected event
// - Compare output reflects counter versus threshold
// - PWM output follows successive compare values
// - Dead-time insertion only in first instance
// - Counts time or events; emits routing triggers
package tcp_pkg;

   // ****************************************
   // Sizes
   // ****************************************
   localparam int STD_WIDTH = 16;
   localparam int WIDE_WIDTH = 32;
   localparam int NUM_CHAN = 4;
   localparam int DT_WIDTH = 8;

   // ****************************************
   // Values after reset
   // ****************************************
   localparam logic [WIDE_WIDTH-1:0] CNT_RESET = 32'h0000_0000;
   localparam logic [DT_WIDTH-1:0] DT_RESET = 8'h00;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      CH_CAPTURE,
      CH_COMPARE,
      CH_PWM,
      CH_OFF
   } tcp_mode_e;

   typedef struct packed {
      tcp_mode_e mode;
      logic [WIDE_WIDTH-1:0] value;
      logic valueWrite;
      logic [1:0] evSel;
   } tcp_chcfg_s;

   typedef struct packed {
      logic enable;
      logic countEvents;
      logic dtEnable;
      logic [DT_WIDTH-1:0] deadTime;
   } tcp_ctrl_s;

endpackage

// File: design/tcp_timer.sv
// Timer with counter, four capture/compare/PWM channels and dead time
`timescale 1ns/100ps
`default_nettype none
module tcp_timer
   import tcp_pkg::*;
#(
   parameter bit WIDE = 1'b0,
   parameter bit FIRST_INSTANCE = 1'b1
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire tcp_ctrl_s ctrl,
   input wire tcp_chcfg_s [NUM_CHAN-1:0] chCfg,
   input wire logic [3:0] eventIn,
   output logic [WIDE_WIDTH-1:0] countOut,
   output logic [NUM_CHAN-1:0][WIDE_WIDTH-1:0] captureOut,
   output logic [NUM_CHAN-1:0] captureStrobe,
   output logic [NUM_CHAN-1:0] chOut,
   output logic [NUM_CHAN-1:0] chOutN,
   output logic overflowTrig,
   output logic [NUM_CHAN-1:0] matchTrig
);

   // ****************************************
   // Width of this variant
   // ****************************************
   localparam int W = WIDE ? WIDE_WIDTH : STD_WIDTH;
   localparam logic [WIDE_WIDTH-1:0] MAXV = {WIDE_WIDTH{1'b1}} >> (WIDE_WIDTH - W);
   localparam bit DT_AVAIL = FIRST_INSTANCE;

   function automatic logic [WIDE_WIDTH-1:0] clip(input logic [WIDE_WIDTH-1:0] v);
      clip = v & MAXV;
   endfunction

   // ****************************************
   // Input synchronisers and event edges
   // ****************************************
   logic [3:0] evMeta_ff;
   logic [3:0] evSync_ff;
   logic [3:0] evLast_ff;
   logic [3:0] evRise;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         evMeta_ff <= 4'h0;
         evSync_ff <= 4'h0;
         evLast_ff <= 4'h0;
      end
      else
      begin
         evMeta_ff <= eventIn;
         evSync_ff <= evMeta_ff;
         evLast_ff <= evSync_ff;
      end
   end

   assign evRise = evSync_ff & ~evLast_ff;

   // ****************************************
   // Counter
   // ****************************************
   logic [WIDE_WIDTH-1:0] count_ff;
   logic tick;
   logic wrap;

   assign tick = ctrl.enable & (ctrl.countEvents ? evRise[0] : 1'b1);
   assign wrap = tick & (count_ff == MAXV);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         count_ff <= CNT_RESET;
      else if (tick)
         count_ff <= wrap ? CNT_RESET : clip(count_ff + 32'h0000_0001);
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         countOut <= CNT_RESET;
         overflowTrig <= 1'b0;
      end
      else
      begin
         countOut <= count_ff;
         overflowTrig <= wrap;
      end
   end

   // ****************************************
   // Channels
   // ****************************************
   logic [NUM_CHAN-1:0][WIDE_WIDTH-1:0] cmp_ff;
   logic [NUM_CHAN-1:0] raw_ff;
   logic [NUM_CHAN-1:0][DT_WIDTH-1:0] dtCnt_ff;
   logic [NUM_CHAN-1:0] rawLast_ff;
   logic [NUM_CHAN-1:0][WIDE_WIDTH-1:0] cmpBuf_ff;
   logic [NUM_CHAN-1:0] bufPend_ff;

   for (genvar c = 0; c < NUM_CHAN; c++)
   begin : g_ch
      logic match;
      logic capEv;
      logic useDt;
      logic rawEdge;
      logic dtStart;
      logic dtQuiet;
      assign match = (count_ff == cmp_ff[c]);
      assign capEv = evRise[chCfg[c].evSel];
      assign useDt = DT_AVAIL & ctrl.dtEnable & (chCfg[c].mode == CH_PWM);

      // Threshold; PWM takes new value at wrap so each period follows writes
      always_ff @(posedge ref_clk)
      begin
         if (rst)
            cmp_ff[c] <= CNT_RESET;
         else if (chCfg[c].valueWrite && (chCfg[c].mode != CH_PWM || wrap))
            cmp_ff[c] <= clip(chCfg[c].value);
         else if (bufPend_ff[c] && wrap)
            cmp_ff[c] <= cmpBuf_ff[c];
      end

      // PWM writes wait here until the next wrap
      always_ff @(posedge ref_clk)
      begin
         if (rst)
         begin
            cmpBuf_ff[c] <= CNT_RESET;
            bufPend_ff[c] <= 1'b0;
         end
         else if (chCfg[c].mode != CH_PWM || wrap)
            bufPend_ff[c] <= 1'b0;
         else if (chCfg[c].valueWrite)
         begin
            cmpBuf_ff[c] <= clip(chCfg[c].value);
            bufPend_ff[c] <= 1'b1;
         end
      end

      // Capture buffer
      always_ff @(posedge ref_clk)
      begin
         if (rst)
         begin
            captureOut[c] <= CNT_RESET;
            captureStrobe[c] <= 1'b0;
         end
         else
         begin
            captureStrobe[c] <= (chCfg[c].mode == CH_CAPTURE) & capEv;
            if (chCfg[c].mode == CH_CAPTURE && capEv)
               captureOut[c] <= count_ff;
         end
      end

      // Raw waveform per mode
      always_ff @(posedge ref_clk)
      begin
         if (rst)
         begin
            raw_ff[c] <= 1'b0;
            matchTrig[c] <= 1'b0;
         end
         else
         begin
            matchTrig[c] <= tick & match & (chCfg[c].mode != CH_CAPTURE);
            unique case (chCfg[c].mode)
               CH_COMPARE: raw_ff[c] <= (count_ff >= cmp_ff[c]);
               CH_PWM: raw_ff[c] <= (count_ff < cmp_ff[c]);
               CH_CAPTURE: raw_ff[c] <= 1'b0;
               CH_OFF: raw_ff[c] <= 1'b0;
            endcase
         end
      end

      // ****************************************
      // Dead time and output stage
      // ****************************************
      // Raw edge opens the gap before either side turns on
      assign rawEdge = (raw_ff[c] != rawLast_ff[c]);
      assign dtStart = useDt & (ctrl.deadTime != DT_RESET);
      assign dtQuiet = (dtCnt_ff[c] == DT_RESET) & ~(rawEdge & dtStart);

      // Dead-time delay after each edge of the raw waveform
      always_ff @(posedge ref_clk)
      begin
         if (rst)
         begin
            rawLast_ff[c] <= 1'b0;
            dtCnt_ff[c] <= DT_RESET;
         end
         else
         begin
            rawLast_ff[c] <= raw_ff[c];
            if (rawEdge && dtStart)
               dtCnt_ff[c] <= ctrl.deadTime - 8'h01;
            else if (dtCnt_ff[c] != DT_RESET)
               dtCnt_ff[c] <= dtCnt_ff[c] - 8'h01;
         end
      end

      // Complementary outputs, both low during dead time
      always_ff @(posedge ref_clk)
      begin
         if (rst)
         begin
            chOut[c] <= 1'b0;
            chOutN[c] <= 1'b0;
         end
         else if (useDt)
         begin
            chOut[c] <= raw_ff[c] & dtQuiet;
            chOutN[c] <= ~raw_ff[c] & dtQuiet;
         end
         else
         begin
            chOut[c] <= raw_ff[c];
            chOutN[c] <= ~raw_ff[c];
         end
      end
   end

endmodule
`default_nettype wire

// File: tb/tcp_timer_sva.sv
// Checker on the timer ports
`timescale 1ns/100ps
`default_nettype none
module tcp_timer_sva
   import tcp_pkg::*;
#(
   parameter bit WIDE = 1'b0
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire tcp_ctrl_s ctrl,
   input wire logic [WIDE_WIDTH-1:0] countOut,
   input wire logic [NUM_CHAN-1:0][WIDE_WIDTH-1:0] captureOut,
   input wire logic [NUM_CHAN-1:0] captureStrobe,
   input wire logic overflowTrig,
   input wire logic [NUM_CHAN-1:0] matchTrig,
   input wire logic [NUM_CHAN-1:0] chOut,
   input wire logic [NUM_CHAN-1:0] chOutN
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_cnt_step: assert property ($past(ctrl.enable, 2) && !$past(ctrl.countEvents, 2)
      && !$past(rst, 2) && !$past(rst) |-> countOut[15:0] == $past(countOut[15:0]) + 16'h1)
      else $error("step");
   a_high_zero: assert property (WIDE || countOut[31:16] == 16'h0) else $error("high");
   a_ovf_wrap: assert property (overflowTrig |=> countOut[15:0] == 16'h0) else $error("wrap");
   a_ovf_pulse: assert property (overflowTrig |=> !overflowTrig) else $error("ovf");
   a_cap_pulse: assert property (captureStrobe[0] |=> !captureStrobe[0]) else $error("cs");
   a_cap_value: assert property (captureStrobe[0] |-> captureOut[0] == countOut) else $error("cv");
   a_cap_hold: assert property (!captureStrobe[0] && !$past(rst)
      |-> $stable(captureOut[0])) else $error("ch");
   a_match_pulse: assert property (matchTrig[1] |=> !matchTrig[1]) else $error("mt");
   a_out_excl: assert property ((chOut & chOutN) == 4'h0) else $error("excl");
   cover property (captureStrobe[0]);
   cover property (overflowTrig);
   cover property (matchTrig[1]);
   cover property (ctrl.dtEnable && !chOut[2] && !chOutN[2]);
endmodule
bind tcp_timer tcp_timer_sva #(.WIDE(WIDE)) chk_u (.ref_clk(ref_clk), .rst(rst), .ctrl(ctrl),
   .countOut(countOut), .captureOut(captureOut), .captureStrobe(captureStrobe),
   .overflowTrig(overflowTrig), .matchTrig(matchTrig), .chOut(chOut), .chOutN(chOutN));
`default_nettype wire

// File: tb/tcp_ev_src.sv
// Event producer model at the event inputs
`timescale 1ns/100ps
`default_nettype none
module tcp_ev_src
(
   input wire logic [3:0] fire,
   output logic [3:0] eventIn
);
   initial eventIn = 4'h0;
   // Async edges, off the clock
   always @(fire)
   begin
      eventIn <= #7 fire;
   end
endmodule
`default_nettype wire

// File: tb/tcp_timer_tb.sv
// Self-checking bench for the timer
`timescale 1ns/100ps
`default_nettype none
module tcp_timer_tb;
   import tcp_pkg::*;
   logic ref_clk;
   logic rst;
   tcp_ctrl_s ctrl;
   tcp_chcfg_s [NUM_CHAN-1:0] chCfg;
   logic [3:0] fire;
   logic [3:0] eventIn;
   logic [WIDE_WIDTH-1:0] countOut;
   logic [NUM_CHAN-1:0][WIDE_WIDTH-1:0] captureOut;
   logic [NUM_CHAN-1:0] captureStrobe;
   logic [NUM_CHAN-1:0] chOut;
   logic [NUM_CHAN-1:0] chOutN;
   logic overflowTrig;
   logic [NUM_CHAN-1:0] matchTrig;
   int badCount;
   int checked;
   tcp_timer #(.WIDE(1'b0), .FIRST_INSTANCE(1'b1)) dut_u (.ref_clk(ref_clk), .rst(rst),
      .ctrl(ctrl), .chCfg(chCfg), .eventIn(eventIn), .countOut(countOut),
      .captureOut(captureOut), .captureStrobe(captureStrobe), .chOut(chOut), .chOutN(chOutN),
      .overflowTrig(overflowTrig), .matchTrig(matchTrig));
   tcp_ev_src ev_u (.fire(fire), .eventIn(eventIn));
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         badCount++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checked %0d bad %0d", checked, badCount);
      if (badCount == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic waitFor(logic [31:0] v);
      for (int i = 0; i < 70000 && countOut !== v; i++) @(negedge ref_clk);
   endtask
   task automatic t_compare();
      chCfg[1].mode = CH_COMPARE;
      chCfg[1].value = 32'h40;
      chCfg[1].valueWrite = 1'b1;
      @(negedge ref_clk);
      chCfg[1].valueWrite = 1'b0;
      ctrl.enable = 1'b1;
      waitFor(32'h3C);
      chk("below", chOut[1], 32'h0);
      waitFor(32'h46);
      chk("above", chOut[1], 32'h1);
   endtask
   task automatic t_capture();
      fire[0] = 1'b1;
      for (int i = 0; i < 10 && captureStrobe[0] !== 1'b1; i++) @(negedge ref_clk);
      chk("strobe", captureStrobe[0], 32'h1);
      chk("capture", captureOut[0], 32'h49);
      fire[0] = 1'b0;
   endtask
   task automatic t_events();
      ctrl.countEvents = 1'b1;
      repeat (10) @(negedge ref_clk);
      chk("held", countOut, 32'h4A);
      repeat (3)
      begin
         fire[0] = 1'b1;
         repeat (5) @(negedge ref_clk);
         fire[0] = 1'b0;
         repeat (5) @(negedge ref_clk);
      end
      chk("events", countOut, 32'h4D);
      ctrl.countEvents = 1'b0;
   endtask
   task automatic t_pwm();
      chCfg[2].mode = CH_COMPARE;
      chCfg[2].value = 32'h100;
      chCfg[2].valueWrite = 1'b1;
      @(negedge ref_clk);
      chCfg[2].valueWrite = 1'b0;
      chCfg[2].mode = CH_PWM;
      ctrl.dtEnable = 1'b1;
      ctrl.deadTime = 8'h03;
      waitFor(32'hFF);
      @(negedge ref_clk);
      chk("pwm high", chOut[2], 32'h1);
      chk("match", matchTrig[2], 32'h1);
      @(negedge ref_clk);
      chk("match end", matchTrig[2], 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         chk("dead p", chOut[2], 32'h0);
         chk("dead n", chOutN[2], 32'h0);
         @(negedge ref_clk);
      end
      chk("pwm low", chOut[2], 32'h0);
      chk("pwm low n", chOutN[2], 32'h1);
      chCfg[2].value = 32'h200;
      chCfg[2].valueWrite = 1'b1;
      @(negedge ref_clk);
      chCfg[2].valueWrite = 1'b0;
      repeat (6) @(negedge ref_clk);
      chk("held thr", chOut[2], 32'h0);
   endtask
   task automatic t_wrap();
      for (int i = 0; i < 70000 && overflowTrig !== 1'b1; i++) @(negedge ref_clk);
      chk("ovf", overflowTrig, 32'h1);
      chk("at max", countOut, 32'hFFFF);
      repeat (10) @(negedge ref_clk);
      chk("step", countOut, 32'h9);
      waitFor(32'h180);
      chk("new thr", chOut[2], 32'h1);
      chk("new thr n", chOutN[2], 32'h0);
   endtask
   initial
   begin
      rst = 1'b1;
      ctrl = '0;
      chCfg = '0;
      fire = 4'h0;
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      t_compare();
      t_capture();
      t_events();
      t_pwm();
      t_wrap();
      close_out();
   end
   initial
   begin
      #(40 * 90000);
      badCount++;
      close_out();
   end
endmodule
`default_nettype wire
